// ### design/gis_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
module gis_clk_div (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// divider setting, half period in cycles minus one
	input wire logic [7:0] halfDiv,
	// divided clock level for the pin
	output logic divClk
);
	import gis_pkg::*;

	logic [7:0] cnt_r, cnt_nxt;
	logic lvl_r, lvl_nxt;

	// ----------------------------------------
	// divider, one enable per half period
	// ----------------------------------------
	always_comb begin
		cnt_nxt = cnt_r + 8'h1;
		lvl_nxt = lvl_r;
		if (cnt_r >= halfDiv) begin
			cnt_nxt = 8'h0;
			lvl_nxt = ~lvl_r;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 8'h0;
			lvl_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign divClk = lvl_r;
endmodule
`default_nettype wire

// ### design/gis_gpio_int.sv
// Function
// RULE1: input mode, register read returns current pin level
// RULE2: output mode drives pin to the programmed level
// RULE3: pin may instead carry an internal clock or the interrupt
// RULE4: separate events for jack, button, short circuit, agc noise
// RULE5: sources routed singly or ORed together onto the pin
// RULE6: status register tells which source fired; host reads it
// RULE7: one pulse per event, or pulse train until status is read
// RULE8: shorted driver limits current; readable flag shows protection active
// RULE9: with auto power-down, a shorted driver is switched off at once
// RULE10: auto-off driver stays off until host powers down then up; clears flag
// RULE11: detected headset type readable after plug detection
// RULE12: host enables short detect with power-down for differential jack sensing
// RULE13: ac-coupled outputs give no trusted mono versus stereo result
// RULE14: short flag also feeds interrupt routing and status
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module gis_gpio_int (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// general purpose pin
	input wire logic gpioIn,
	output logic gpioOut,
	output logic gpioOe,
	// analog side events and state
	input wire logic jackDetect,
	input wire logic buttonPress,
	input wire logic agcNoise,
	input wire logic [gis_pkg::GIS_NDRV-1:0] drvShorted,
	input wire logic [1:0] headsetType,
	// driver power control
	output logic [gis_pkg::GIS_NDRV-1:0] drvPowerOn,
	output logic [gis_pkg::GIS_NDRV-1:0] drvCurrentLimit,
	// interrupt
	output logic irq
);
	import gis_pkg::*;

	logic [1:0] pinMode_r, pinMode_nxt;
	logic outLevel_r, outLevel_nxt;
	logic train_r, train_nxt;
	logic [GIS_NSRC-1:0] intSel_r, intSel_nxt;
	logic [GIS_NSRC-1:0] status_r, status_nxt;
	logic [GIS_NSRC-1:0] mask_r, mask_nxt;
	logic autoPd_r, autoPd_nxt;
	logic [GIS_NDRV-1:0] shortFlag_r, shortFlag_nxt;
	logic [GIS_NDRV-1:0] pwrReq_r, pwrReq_nxt;
	logic [GIS_NDRV-1:0] autoOff_r, autoOff_nxt;
	logic [1:0] hsType_r, hsType_nxt;
	logic acCoupled_r, acCoupled_nxt;
	logic [7:0] clkDiv_r, clkDiv_nxt;
	logic [GIS_NSRC-1:0] srcLvl_r, srcLvl_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [GIS_NSRC-1:0] srcNow, srcRise;
	logic anyRise, statusRead, divClk;
	logic [1:0] hsView;

	gis_pulse_if pif();

	function automatic logic wrHit(input logic [7:0] a, input logic [7:0] off);
		return regWr && (a == off);
	endfunction

	// ----------------------------------------
	// event sources
	// ----------------------------------------
	always_comb begin
		srcNow = '0;
		srcNow[GIS_SRC_JACK] = jackDetect; // [RULE4]
		srcNow[GIS_SRC_BUTTON] = buttonPress;
		srcNow[GIS_SRC_SHORT] = |shortFlag_r; // [RULE14]
		srcNow[GIS_SRC_AGC] = agcNoise;
	end
	assign srcRise = srcNow & ~srcLvl_r;
	assign anyRise = |(srcRise & intSel_r); // [RULE5]
	assign statusRead = regRd && (regAddr == GIS_REG_STATUS);
	// merged at readout, so an ac-coupled setting made after the plug also hides the split
	assign hsView = (acCoupled_r && hsType_r == GIS_HS_MONO) ? GIS_HS_STEREO_AC : hsType_r; // [RULE13]

	// ----------------------------------------
	// register next state
	// ----------------------------------------
	always_comb begin
		pinMode_nxt = pinMode_r;
		outLevel_nxt = outLevel_r;
		train_nxt = train_r;
		intSel_nxt = intSel_r;
		mask_nxt = mask_r;
		autoPd_nxt = autoPd_r;
		pwrReq_nxt = pwrReq_r;
		clkDiv_nxt = clkDiv_r;
		acCoupled_nxt = acCoupled_r;
		srcLvl_nxt = srcNow;
		if (wrHit(regAddr, GIS_REG_PINCFG)) begin
			pinMode_nxt = regWdata[1:0]; // [RULE3]
			outLevel_nxt = regWdata[GIS_CFG_OUTLVL]; // [RULE2]
			train_nxt = regWdata[GIS_CFG_TRAIN]; // [RULE7]
		end
		if (wrHit(regAddr, GIS_REG_INTSEL))
			intSel_nxt = regWdata[GIS_NSRC-1:0];
		if (wrHit(regAddr, GIS_REG_MASK))
			mask_nxt = regWdata[GIS_NSRC-1:0];
		if (wrHit(regAddr, GIS_REG_SHORT))
			autoPd_nxt = regWdata[GIS_SHORT_AUTOPD];
		if (wrHit(regAddr, GIS_REG_DRVPWR))
			pwrReq_nxt = regWdata[GIS_NDRV-1:0];
		if (wrHit(regAddr, GIS_REG_CLKDIV))
			clkDiv_nxt = regWdata[7:0];
		if (wrHit(regAddr, GIS_REG_HSTYPE))
			acCoupled_nxt = regWdata[GIS_HS_AC];
		// status: write one to clear, also cleared by read; set wins
		status_nxt = status_r;
		if (wrHit(regAddr, GIS_REG_STATUS))
			status_nxt = status_nxt & ~regWdata[GIS_NSRC-1:0];
		if (statusRead)
			status_nxt = '0; // [RULE6]
		status_nxt = status_nxt | srcRise; // [RULE6]
		// short flags and auto power-down
		shortFlag_nxt = shortFlag_r | drvShorted; // [RULE8]
		autoOff_nxt = autoOff_r;
		for (int i = 0; i < GIS_NDRV; i++) begin
			if (autoPd_r && drvShorted[i])
				autoOff_nxt[i] = 1'b1; // [RULE9]
			if (!pwrReq_r[i] && !drvShorted[i]) begin
				autoOff_nxt[i] = 1'b0; // [RULE10]
				shortFlag_nxt[i] = 1'b0; // [RULE10]
			end
		end
		// headset type latched raw on plug
		hsType_nxt = hsType_r;
		if (srcRise[GIS_SRC_JACK])
			hsType_nxt = headsetType; // [RULE11]
		if (!jackDetect)
			hsType_nxt = 2'h0;
	end

	// ----------------------------------------
	// read mux, data one cycle later
	// ----------------------------------------
	always_comb begin
		rdata_nxt = 32'h0;
		if (regRd) begin
			case (regAddr)
				GIS_REG_PINCFG: rdata_nxt = {28'h0, train_r, outLevel_r, pinMode_r};
				GIS_REG_INTSEL: rdata_nxt = {28'h0, intSel_r};
				GIS_REG_STATUS: rdata_nxt = {28'h0, status_r};
				GIS_REG_MASK: rdata_nxt = {28'h0, mask_r};
				GIS_REG_SHORT: rdata_nxt = {28'h0, autoPd_r, shortFlag_r}; // [RULE8]
				GIS_REG_DRVPWR: rdata_nxt = {25'h0, gpioIn, autoOff_r, pwrReq_r}; // [RULE1]
				GIS_REG_HSTYPE: rdata_nxt = {29'h0, acCoupled_r, hsView}; // [RULE11]
				GIS_REG_PULSE: rdata_nxt = {31'h0, pif.pulseOut};
				GIS_REG_CLKDIV: rdata_nxt = {24'h0, clkDiv_r};
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinMode_r <= GIS_MODE_IN;
			outLevel_r <= 1'b0;
			train_r <= 1'b0;
			intSel_r <= '0;
			status_r <= '0;
			mask_r <= '0;
			autoPd_r <= 1'b0;
			shortFlag_r <= '0;
			pwrReq_r <= GIS_RST_DRVPWR;
			autoOff_r <= '0;
			hsType_r <= 2'h0;
			acCoupled_r <= 1'b0;
			clkDiv_r <= 8'h0;
			srcLvl_r <= '0;
			rdata_r <= GIS_RST_ZERO;
		end else begin
			pinMode_r <= pinMode_nxt;
			outLevel_r <= outLevel_nxt;
			train_r <= train_nxt;
			intSel_r <= intSel_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			autoPd_r <= autoPd_nxt;
			shortFlag_r <= shortFlag_nxt;
			pwrReq_r <= pwrReq_nxt;
			autoOff_r <= autoOff_nxt;
			hsType_r <= hsType_nxt;
			acCoupled_r <= acCoupled_nxt;
			clkDiv_r <= clkDiv_nxt;
			srcLvl_r <= srcLvl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// pulse generator and clock divider
	// ----------------------------------------
	assign pif.event1 = anyRise; // [RULE5]
	assign pif.train = train_r;
	// train stops once every routed source has been read out
	assign pif.pending = |(status_r & intSel_r) && !statusRead; // [RULE7]

	gis_pulse_gen #(
		.HIGH_CYC(GIS_PULSE_CYC),
		.PERIOD_CYC(GIS_TRAIN_PERIOD)
	) u_pulse (
		.clk(clk),
		.reset_n(reset_n),
		.pif(pif.gen)
	);

	gis_clk_div u_div (
		.clk(clk),
		.reset_n(reset_n),
		.halfDiv(clkDiv_r),
		.divClk(divClk)
	);

	// ----------------------------------------
	// pin mux and outputs
	// ----------------------------------------
	always_comb begin
		gpioOut = 1'b0;
		gpioOe = 1'b1;
		case (pinMode_r)
			GIS_MODE_IN: gpioOe = 1'b0; // [RULE1]
			GIS_MODE_OUT: gpioOut = outLevel_r; // [RULE2]
			GIS_MODE_CLK: gpioOut = divClk; // [RULE3]
			GIS_MODE_INT: gpioOut = pif.pulseOut; // [RULE3]
			default: gpioOe = 1'b0;
		endcase
	end

	// current limit always active while shorted; auto-off removes power
	assign drvCurrentLimit = drvShorted; // [RULE8]
	assign drvPowerOn = pwrReq_r & ~autoOff_r; // [RULE9]
	assign irq = |(status_r & mask_r);
	assign regRdata = rdata_r;
endmodule
`default_nettype wire

// ### design/gis_pulse_gen.sv
`timescale 1ns/10ps
`default_nettype none
module gis_pulse_gen #(
	parameter int HIGH_CYC = 10,
	parameter int PERIOD_CYC = 40
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pulse request
	gis_pulse_if.gen pif
);
	import gis_pkg::*;

	initial begin
		if (HIGH_CYC < 1 || PERIOD_CYC <= HIGH_CYC || PERIOD_CYC > 65535)
			$error("gis_pulse_gen: bad pulse timing");
	end

	gis_pstate_t state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic out_r, out_nxt;

	// ----------------------------------------
	// single pulse or train until status read
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		out_nxt = out_r;
		case (state_r)
			GIS_PS_IDLE: begin
				if (pif.event1) begin // [RULE7]
					state_nxt = GIS_PS_HIGH;
					cnt_nxt = 16'h0;
					out_nxt = 1'b1;
				end
			end
			GIS_PS_HIGH: begin
				cnt_nxt = cnt_r + 16'h1;
				if (cnt_r == 16'(HIGH_CYC - 1)) begin
					out_nxt = 1'b0;
					state_nxt = GIS_PS_GAP;
				end
			end
			GIS_PS_GAP: begin
				cnt_nxt = cnt_r + 16'h1;
				// train repeats while status stays unread
				if (cnt_r == 16'(PERIOD_CYC - 1)) begin
					if (pif.train && pif.pending) begin // [RULE7]
						state_nxt = GIS_PS_HIGH;
						cnt_nxt = 16'h0;
						out_nxt = 1'b1;
					end else begin
						state_nxt = GIS_PS_IDLE;
					end
				end
			end
			default: begin
				state_nxt = GIS_PS_IDLE;
				out_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= GIS_PS_IDLE;
			cnt_r <= 16'h0;
			out_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end

	assign pif.pulseOut = out_r;
endmodule
`default_nettype wire

// ### include/gis_pkg.sv
package gis_pkg;
	// ----------------------------------------
	// register map (byte offsets, one 32-bit word apart, byte address = offset)
	// ----------------------------------------
	localparam logic [7:0] GIS_REG_PINCFG = 8'h00;
	localparam logic [7:0] GIS_REG_INTSEL = 8'h04;
	localparam logic [7:0] GIS_REG_STATUS = 8'h08;
	localparam logic [7:0] GIS_REG_MASK = 8'h0c;
	localparam logic [7:0] GIS_REG_SHORT = 8'h10;
	localparam logic [7:0] GIS_REG_DRVPWR = 8'h14;
	localparam logic [7:0] GIS_REG_HSTYPE = 8'h18;
	localparam logic [7:0] GIS_REG_PULSE = 8'h1c;
	localparam logic [7:0] GIS_REG_CLKDIV = 8'h20;
	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int GIS_NSRC = 4;
	localparam int GIS_NDRV = 3;
	localparam int GIS_SRC_JACK = 0;
	localparam int GIS_SRC_BUTTON = 1;
	localparam int GIS_SRC_SHORT = 2;
	localparam int GIS_SRC_AGC = 3;
	localparam int GIS_CFG_OUTLVL = 2;
	localparam int GIS_CFG_TRAIN = 3;
	localparam int GIS_SHORT_AUTOPD = 3;
	localparam int GIS_HS_AC = 2;
	localparam logic [1:0] GIS_HS_MONO = 2'h1;
	localparam logic [1:0] GIS_HS_STEREO = 2'h2;
	localparam logic [1:0] GIS_HS_STEREO_AC = 2'h2;
	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [31:0] GIS_RST_ZERO = 32'h0;
	localparam logic [2:0] GIS_RST_DRVPWR = 3'h0;
	localparam int GIS_PULSE_NS = 100;
	localparam int GIS_CLK_NS = 10;
	localparam int GIS_PULSE_CYC = (GIS_PULSE_NS + GIS_CLK_NS - 1) / GIS_CLK_NS;
	localparam int GIS_TRAIN_PERIOD = 4 * GIS_PULSE_CYC;

	typedef enum logic [1:0] {
		GIS_MODE_IN = 2'b00,
		GIS_MODE_OUT = 2'b01,
		GIS_MODE_CLK = 2'b10,
		GIS_MODE_INT = 2'b11
	} gis_mode_t;

	typedef enum logic [1:0] {
		GIS_PS_IDLE = 2'b00,
		GIS_PS_HIGH = 2'b01,
		GIS_PS_GAP = 2'b10
	} gis_pstate_t;
endpackage

// ### include/gis_pulse_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gis_pulse_if;
	logic event1;
	logic train;
	logic pending;
	logic pulseOut;
	modport ctrl(output event1, output train, output pending, input pulseOut);
	modport gen(input event1, input train, input pending, output pulseOut);
endinterface
`default_nettype wire

// ### sim/gis_gpio_int_properties.sv
`timescale 1ns/10ps
`default_nettype none
module gis_gpio_int_properties (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	// pin and analog side
	input wire logic gpioIn,
	input wire logic gpioOut,
	input wire logic gpioOe,
	input wire logic jackDetect,
	input wire logic buttonPress,
	input wire logic agcNoise,
	input wire logic [gis_pkg::GIS_NDRV-1:0] drvShorted,
	input wire logic [1:0] headsetType,
	input wire logic [gis_pkg::GIS_NDRV-1:0] drvPowerOn,
	input wire logic [gis_pkg::GIS_NDRV-1:0] drvCurrentLimit,
	input wire logic irq
);
	import gis_pkg::*;
	// ----------------------------------------
	// shadow of written settings
	// ----------------------------------------
	logic [3:0] pinCfg_r;
	logic [2:0] pwr_r;
	logic autoPd_r;
	logic [5:0] evtPrev_r;
	logic [2:0] quiet_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinCfg_r <= 4'h0;
			pwr_r <= GIS_RST_DRVPWR;
			autoPd_r <= 1'b0;
			evtPrev_r <= 6'h00;
			quiet_r <= 3'h0;
		end else begin
			evtPrev_r <= {jackDetect, buttonPress, agcNoise, drvShorted};
			// events go through flag and edge stages, so wait a few quiet cycles
			if (evtPrev_r != {jackDetect, buttonPress, agcNoise, drvShorted}) begin
				quiet_r <= 3'h0;
			end else if (quiet_r != 3'h7) begin
				quiet_r <= quiet_r + 3'h1;
			end
			if (regWr && regAddr == GIS_REG_PINCFG) begin
				pinCfg_r <= regWdata[3:0];
			end
			if (regWr && regAddr == GIS_REG_DRVPWR) begin
				pwr_r <= regWdata[2:0];
			end
			if (regWr && regAddr == GIS_REG_SHORT) begin
				autoPd_r <= regWdata[GIS_SHORT_AUTOPD];
			end
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_limit_follows:
		assert property (drvCurrentLimit == drvShorted) else $error("limit differs from short");
	a_pin_read:
		assert property ($stable(gpioIn)[*4] ##0 (regRd && regAddr == GIS_REG_DRVPWR) |=> regRdata[6] == $past(gpioIn))
			else $error("pin level not read back");
	a_out_level:
		assert property (pinCfg_r[1:0] == GIS_MODE_OUT |-> gpioOe && gpioOut == pinCfg_r[GIS_CFG_OUTLVL])
			else $error("output level wrong");
	a_pulse_width:
		assert property (pinCfg_r[1:0] == GIS_MODE_INT && !pinCfg_r[GIS_CFG_TRAIN] && $rose(gpioOut)
			|-> gpioOut[*8] ##1 gpioOut[*2] ##1 !gpioOut) else $error("pulse not ten cycles");
	a_power_req:
		assert property ((drvPowerOn & ~pwr_r) == 3'h0) else $error("driver on without request");
	a_auto_off:
		assert property (autoPd_r && $rose(drvShorted[0]) |-> ##[0:3] !drvPowerOn[0])
			else $error("shorted driver not powered down");
	a_ac_nosplit:
		assert property (regRd && regAddr == GIS_REG_HSTYPE |=> !(regRdata[GIS_HS_AC] && regRdata[1:0] == GIS_HS_MONO))
			else $error("mono reported while ac coupled");
	a_read_clears:
		assert property (quiet_r > 3'h3 && regRd && regAddr == GIS_REG_STATUS |=> !irq)
			else $error("irq stays after status read");
	c_pulse: cover property (pinCfg_r[1:0] == GIS_MODE_INT && $rose(gpioOut));
	c_auto_off: cover property (autoPd_r && $fell(drvPowerOn[0]));
	c_irq: cover property ($rose(irq));
endmodule
bind gis_gpio_int gis_gpio_int_properties gis_gpio_int_properties_inst (.clk(clk), .reset_n(reset_n),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .jackDetect(jackDetect),
	.buttonPress(buttonPress), .agcNoise(agcNoise), .drvShorted(drvShorted), .headsetType(headsetType),
	.drvPowerOn(drvPowerOn), .drvCurrentLimit(drvCurrentLimit), .irq(irq));
`default_nettype wire

// ### sim/gis_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module gis_host_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pin as seen by the host
	input wire logic gpioOut,
	input wire logic gpioOe,
	// pulses seen
	output logic [7:0] pulseCount
);
	logic last_r;
	// an undriven pin never counts, so a float cannot fake a pulse
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			last_r <= 1'b0;
			pulseCount <= 8'h00;
		end else begin
			last_r <= gpioOe && gpioOut;
			if (gpioOe && gpioOut && !last_r) begin
				pulseCount <= pulseCount + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/test_gis_gpio_int.sv
`timescale 1ns/10ps
`default_nettype none
module test_gis_gpio_int;
	import gis_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	logic extLevel = 1'b0;
	wire logic gpioIn;
	logic gpioOut;
	logic gpioOe;
	logic jackDetect = 1'b0;
	logic buttonPress = 1'b0;
	logic agcNoise = 1'b0;
	logic [2:0] drvShorted = 3'h0;
	logic [1:0] headsetType = 2'h0;
	logic [2:0] drvPowerOn;
	logic [2:0] drvCurrentLimit;
	logic irq;
	logic [7:0] pulseCount;
	logic [31:0] rdv;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	int i;
	int n;
	// pin wire: our own drive wins, else the outside level
	assign gpioIn = gpioOe ? gpioOut : extLevel;
	always #5 clk = ~clk;
	gis_gpio_int gis_gpio_int_inst (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .gpioIn(gpioIn), .gpioOut(gpioOut),
		.gpioOe(gpioOe), .jackDetect(jackDetect), .buttonPress(buttonPress), .agcNoise(agcNoise),
		.drvShorted(drvShorted), .headsetType(headsetType), .drvPowerOn(drvPowerOn),
		.drvCurrentLimit(drvCurrentLimit), .irq(irq));
	gis_host_model gis_host_model_inst (.clk(clk), .reset_n(reset_n), .gpioOut(gpioOut), .gpioOe(gpioOe),
		.pulseCount(pulseCount));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rdv = regRdata;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic set_src(input int s, input logic v);
		case (s)
			GIS_SRC_JACK: jackDetect <= v;
			GIS_SRC_BUTTON: buttonPress <= v;
			GIS_SRC_SHORT: drvShorted <= {2'b00, v};
			default: agcNoise <= v;
		endcase
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		tick(1);
		chk(32'({irq, gpioOe, gpioOut, drvPowerOn}), 32'h0, "reset outputs");
		rd(8'hfc);
		chk(rdv, 32'h0, "unmapped read");
		for (i = 0; i < 2; i++) begin
			wr(GIS_REG_PINCFG, 32'h0);
			@(posedge clk) extLevel <= i[0];
			tick(4);
			rd(GIS_REG_DRVPWR);
			chk(32'(rdv[6]), 32'(i), "pin input");
			wr(GIS_REG_PINCFG, 32'(1 + 4 * i));
			tick(1);
			chk(32'({gpioOe, gpioOut}), 32'(2 + i), "pin output");
		end
		wr(GIS_REG_CLKDIV, 32'h1);
		wr(GIS_REG_PINCFG, 32'h2);
		n = 0;
		for (i = 0; i < 20; i++) begin
			tick(1);
			if (gpioOut === 1'b1) n++;
		end
		chk(32'(gpioOe === 1'b1 && n > 5 && n < 15), 32'h1, "clock on pin");
		wr(GIS_REG_PINCFG, 32'h0);
		wr(GIS_REG_MASK, 32'hf);
		for (i = 0; i < GIS_NSRC; i++) begin
			@(posedge clk) set_src(i, 1'b1);
			tick(6);
			chk(32'(irq), 32'h1, "irq raised");
			rd(GIS_REG_STATUS);
			chk(rdv, 32'h1 << i, "status source");
			@(posedge clk) set_src(i, 1'b0);
			tick(6);
			chk(32'(irq), 32'h0, "cleared by read");
		end
		wr(GIS_REG_MASK, 32'h0);
		@(posedge clk) set_src(GIS_SRC_AGC, 1'b1);
		tick(6);
		chk(32'(irq), 32'h0, "masked");
		wr(GIS_REG_MASK, 32'h8);
		tick(1);
		chk(32'(irq), 32'h1, "unmasked");
		wr(GIS_REG_STATUS, 32'h8);
		tick(1);
		chk(32'(irq), 32'h0, "write one clears");
		@(posedge clk) set_src(GIS_SRC_AGC, 1'b0);
		wr(GIS_REG_INTSEL, 32'h3);
		wr(GIS_REG_PINCFG, 32'h3);
		for (i = 0; i < 3; i++) begin
			n = int'(pulseCount);
			@(posedge clk) set_src(i == 2 ? GIS_SRC_AGC : i, 1'b1);
			tick(60);
			chk(32'(int'(pulseCount) - n), 32'(i < 2), "routed pulse");
			@(posedge clk) set_src(i == 2 ? GIS_SRC_AGC : i, 1'b0);
		end
		rd(GIS_REG_STATUS);
		wr(GIS_REG_PINCFG, 32'hb);
		n = int'(pulseCount);
		@(posedge clk) set_src(GIS_SRC_BUTTON, 1'b1);
		tick(130);
		chk(32'(int'(pulseCount) - n > 2), 32'h1, "pulse train");
		rd(GIS_REG_STATUS);
		chk(rdv, 32'h2, "train cause");
		tick(50);
		n = int'(pulseCount);
		tick(100);
		chk(32'(int'(pulseCount) - n), 32'h0, "train ends");
		@(posedge clk) set_src(GIS_SRC_BUTTON, 1'b0);
		wr(GIS_REG_PINCFG, 32'h0);
		wr(GIS_REG_DRVPWR, 32'h7);
		wr(GIS_REG_SHORT, 32'h8);
		@(posedge clk) drvShorted <= 3'h1;
		tick(4);
		chk(32'({drvCurrentLimit, drvPowerOn}), 32'h0e, "auto power-down");
		rd(GIS_REG_SHORT);
		chk(rdv, 32'h9, "short flag");
		@(posedge clk) drvShorted <= 3'h0;
		tick(4);
		chk(32'(drvPowerOn), 32'h6, "stays off");
		wr(GIS_REG_DRVPWR, 32'h6);
		wr(GIS_REG_DRVPWR, 32'h7);
		rd(GIS_REG_SHORT);
		chk(32'({drvPowerOn, rdv[3:0]}), 32'h78, "recovered");
		@(posedge clk) begin
			jackDetect <= 1'b1;
			headsetType <= GIS_HS_MONO;
		end
		tick(4);
		rd(GIS_REG_HSTYPE);
		chk(rdv, 32'(GIS_HS_MONO), "headset type");
		wr(GIS_REG_HSTYPE, 32'h4);
		rd(GIS_REG_HSTYPE);
		chk(rdv, 32'(4 + GIS_HS_STEREO_AC), "ac coupled type");
		finish_test();
	end
endmodule
`default_nettype wire
